// >>> hw/dacec_top.sv
/*
 * Four-channel 8-bit converter control with APB register access.
 * Assumes an APB master on sys_clk_in; analog circuits take result/drive outs.
 */
// Summary of operation
// - Low pair, gang clear: channel 0 and 1 each converts from own enable.
// - Low pair, gang set: both convert if either enable set.
// - High pair, gang clear: channel 2 bit 6, channel 3 bit 7, independent.
// - High pair, gang bit 5 set: both convert if either enable set.
// - Analog output driven only by channel's own enable, regardless of ganging.
// - High control: ch3 enable bit 7, ch2 bit 6, read/write, reset 0.
// - Control bits 4..0 read one, writes ignored.
// - Four channels operate independently except pairwise ganging.
// - Enable starts conversion; result held until rewrite or disable.
// - Rewriting an enabled sample restarts conversion on the clock after the write lands.
// - Clearing an enable stops driving that analog output.
// - Module stop at reset keeps converter idle and blocks access to all registers except power control.
// - In software standby, enabled outputs hold their present value.
// - One 8-bit read/write sample register per channel, converted when enabled.
// - Each conversion counts 10 microseconds (250 clocks at 25 MHz) before the result is valid.
`timescale 1ns/1ns

module dacec_top
    import dacec_pkg::*;
(
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic      [`DACEC_NUM_CH-1:0] drive_en_out,
    output logic      [`DACEC_NUM_CH-1:0] result_valid_out,
    output logic      [`DACEC_DATA_W-1:0] analog_out_ch0,
    output logic      [`DACEC_DATA_W-1:0] analog_out_ch1,
    output logic      [`DACEC_DATA_W-1:0] analog_out_ch2,
    output logic      [`DACEC_DATA_W-1:0] analog_out_ch3
);
    dacec_sample_t             sample_q [`DACEC_NUM_CH];
    logic [1:0]                oe_low_q;
    logic [1:0]                oe_high_q;
    logic                      gang_low_q;
    logic                      gang_high_q;
    logic                      mstop_q;
    logic                      standby_q;
    logic [`DACEC_NUM_CH-1:0]  restart_q;
    logic [`DACEC_NUM_CH-1:0]  run_q;
    logic [`DACEC_NUM_CH-1:0]  oe_all;
    logic [`DACEC_NUM_CH-1:0]  run_d;
    logic [`DACEC_NUM_CH-1:0]  valid_w;
    dacec_sample_t             result_w [`DACEC_NUM_CH];
    logic                      wr_stb;
    logic                      acc_ok;
    logic [`DACEC_ADDR_W-1:0]  addr;
    logic [31:0]               rdata_d;
    logic                      err_d;
    logic [7:0]                low_ctrl;
    logic [7:0]                high_ctrl;

    assign addr   = paddr[`DACEC_ADDR_W-1:0];
    assign oe_all = {oe_high_q, oe_low_q};
    assign acc_ok = !mstop_q || addr == `DACEC_OFS_PWR_CTRL;
    assign wr_stb = psel && penable && pwrite && pready && acc_ok;

    assign low_ctrl  = {oe_low_q, gang_low_q, 5'(`DACEC_RSVD_ONES)};
    // high enables at 7 and 6
    assign high_ctrl = {oe_high_q, gang_high_q, 5'(`DACEC_RSVD_ONES)};

    // Zero-wait slave; one cycle in access phase
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
        end
    end

    always_comb
    begin
        rdata_d = `DACEC_ZERO32;
        err_d   = 1'b0;
        if (!acc_ok)
        begin
            err_d = 1'b1;
        end
        else
        begin
            case (addr)
                `DACEC_OFS_SAMPLE0:   rdata_d = {24'h00_0000, sample_q[0]};
                `DACEC_OFS_SAMPLE1:   rdata_d = {24'h00_0000, sample_q[1]};
                `DACEC_OFS_SAMPLE2:   rdata_d = {24'h00_0000, sample_q[2]};
                `DACEC_OFS_SAMPLE3:   rdata_d = {24'h00_0000, sample_q[3]};
                `DACEC_OFS_LOW_CTRL:  rdata_d = {24'h00_0000, low_ctrl};
                `DACEC_OFS_HIGH_CTRL: rdata_d = {24'h00_0000, high_ctrl};
                `DACEC_OFS_PWR_CTRL:  rdata_d = {30'h0000_0000, standby_q, mstop_q};
                `DACEC_OFS_STATUS:    rdata_d = {24'h00_0000, run_q, result_valid_out};
                default:              err_d   = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prdata  <= `DACEC_ZERO32;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= pwrite ? `DACEC_ZERO32 : rdata_d;
            pslverr <= err_d;
        end
    end

    // Power control: module stop and standby request
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mstop_q   <= `DACEC_MSTOP_RESET;
            standby_q <= 1'b0;
        end
        else if (wr_stb && addr == `DACEC_OFS_PWR_CTRL)
        begin
            mstop_q   <= pwdata[`DACEC_BIT_MSTOP];
            standby_q <= pwdata[`DACEC_BIT_STANDBY];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            oe_low_q    <= 2'b00;
            oe_high_q   <= 2'b00;
            gang_low_q  <= 1'b0;
            gang_high_q <= 1'b0;
        end
        else if (wr_stb && addr == `DACEC_OFS_LOW_CTRL)
        begin
            oe_low_q   <= {pwdata[`DACEC_BIT_OE_HI], pwdata[`DACEC_BIT_OE_LO]};
            gang_low_q <= pwdata[`DACEC_BIT_GANG];
        end
        else if (wr_stb && addr == `DACEC_OFS_HIGH_CTRL)
        begin
            // ch3 bit 7, ch2 bit 6
            oe_high_q   <= {pwdata[`DACEC_BIT_OE_HI], pwdata[`DACEC_BIT_OE_LO]};
            gang_high_q <= pwdata[`DACEC_BIT_GANG];
        end
    end

    always_comb
    begin
        run_d[0] = gang_low_q ? |oe_low_q : oe_low_q[0];
        run_d[1] = gang_low_q ? |oe_low_q : oe_low_q[1];
        run_d[2] = gang_high_q ? |oe_high_q : oe_high_q[0];
        run_d[3] = gang_high_q ? |oe_high_q : oe_high_q[1];
        if (mstop_q)
        begin
            run_d = '0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DACEC_NUM_CH; gi++)
        begin : g_ch
            dacec_chan_if cif ();

            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    sample_q[gi] <= `DACEC_SAMPLE_RESET;
                end
                else if (wr_stb && addr == `DACEC_ADDR_W'(`DACEC_OFS_SAMPLE0 + 4 * gi))
                begin
                    sample_q[gi] <= pwdata[`DACEC_DATA_W-1:0];
                end
            end

            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    restart_q[gi] <= 1'b0;
                    run_q[gi]     <= 1'b0;
                end
                else
                begin
                    // Kept through standby so a rewrite there still converts
                    restart_q[gi] <= (standby_q && restart_q[gi]) || (wr_stb
                        && addr == `DACEC_ADDR_W'(`DACEC_OFS_SAMPLE0 + 4 * gi));
                    run_q[gi]     <= standby_q ? run_q[gi] : run_d[gi];
                end
            end

            assign cif.run     = run_q[gi];
            assign cif.restart = restart_q[gi];
            assign cif.freeze  = standby_q;
            assign cif.sample  = sample_q[gi];
            assign valid_w[gi]  = cif.valid;
            assign result_w[gi] = cif.result;

            dacec_channel u_chan
            (
                .sys_clk_in (sys_clk_in),
                .rst_n_in   (rst_n_in),
                .ch         (cif.chan)
            );

            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    drive_en_out[gi]     <= 1'b0;
                    result_valid_out[gi] <= 1'b0;
                end
                else if (!standby_q)
                begin
                    drive_en_out[gi]     <= oe_all[gi] && !mstop_q;
                    result_valid_out[gi] <= valid_w[gi];
                end
            end
        end
    endgenerate

    // Result registered so outputs come from flops; one-cycle lag accepted
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            analog_out_ch0 <= `DACEC_SAMPLE_RESET;
            analog_out_ch1 <= `DACEC_SAMPLE_RESET;
            analog_out_ch2 <= `DACEC_SAMPLE_RESET;
            analog_out_ch3 <= `DACEC_SAMPLE_RESET;
        end
        else if (!standby_q)
        begin
            analog_out_ch0 <= result_w[0];
            analog_out_ch1 <= result_w[1];
            analog_out_ch2 <= result_w[2];
            analog_out_ch3 <= result_w[3];
        end
    end
endmodule

// >>> hw/dacec_cfg.svh
/*
 * Constants for the four-channel converter control block: register offsets,
 * field positions, reset values and conversion timing.
 * Assumes inclusion by bare name from the package, the port checker and the bench.
 */
`ifndef DACEC_CFG_SVH
`define DACEC_CFG_SVH

`define DACEC_NUM_CH          4
`define DACEC_DATA_W          8
`define DACEC_ADDR_W          8

`define DACEC_OFS_SAMPLE0     8'h00
`define DACEC_OFS_SAMPLE1     8'h04
`define DACEC_OFS_SAMPLE2     8'h08
`define DACEC_OFS_SAMPLE3     8'h0C
`define DACEC_OFS_LOW_CTRL    8'h10
`define DACEC_OFS_HIGH_CTRL   8'h14
`define DACEC_OFS_PWR_CTRL    8'h18
`define DACEC_OFS_STATUS      8'h1C

`define DACEC_BIT_OE_HI       7
`define DACEC_BIT_OE_LO       6
`define DACEC_BIT_GANG        5
`define DACEC_RSVD_ONES       8'h1F
`define DACEC_CTRL_RESET      8'h1F
`define DACEC_SAMPLE_RESET    8'h00

`define DACEC_BIT_MSTOP       0
`define DACEC_BIT_STANDBY     1
`define DACEC_MSTOP_RESET     1'b1

`define DACEC_CLK_MHZ         25
`define DACEC_CONV_TIME_NS    10000
`define DACEC_CONV_CYCLES     ((`DACEC_CONV_TIME_NS * `DACEC_CLK_MHZ) / 1000)
`define DACEC_CNT_W           9

`define DACEC_ZERO32          32'h0000_0000

`endif

// >>> hw/dacec_pkg.sv
/*
 * Types shared by the converter control modules.
 * Assumes dacec_cfg.svh is on the include path.
 */
`include "dacec_cfg.svh"

package dacec_pkg;
    typedef logic [`DACEC_DATA_W-1:0] dacec_sample_t;
    typedef logic [`DACEC_CNT_W-1:0]  dacec_count_t;
    typedef enum logic [1:0]
    {
        DACEC_IDLE,
        DACEC_CONVERTING,
        DACEC_HOLDING
    } dacec_state_t;
endpackage

// >>> hw/dacec_chan_if.sv
/*
 * Carrier between the register block and one conversion channel.
 * Assumes both ends share sys_clk_in and rst_n_in.
 */
`timescale 1ns/1ns

interface dacec_chan_if;
    import dacec_pkg::*;
    logic          run;
    logic          restart;
    logic          freeze;
    dacec_sample_t sample;
    logic          valid;
    dacec_sample_t result;

    modport ctrl
    (
        output run,
        output restart,
        output freeze,
        output sample,
        input  valid,
        input  result
    );
    modport chan
    (
        input  run,
        input  restart,
        input  freeze,
        input  sample,
        output valid,
        output result
    );
endinterface

// >>> hw/dacec_channel.sv
/*
 * One conversion channel: counts the conversion time, then latches the
 * sample as result and raises valid.
 * Assumes run/restart/freeze come from the register block's flops.
 */
`timescale 1ns/1ns

module dacec_channel
    import dacec_pkg::*;
(
    input  wire logic   sys_clk_in,
    input  wire logic   rst_n_in,
    dacec_chan_if.chan  ch
);
    localparam dacec_count_t CONV_LAST = dacec_count_t'(`DACEC_CONV_CYCLES - 1);

    dacec_state_t state_q;
    dacec_count_t cnt_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q   <= DACEC_IDLE;
            cnt_q     <= '0;
            ch.valid  <= 1'b0;
            ch.result <= `DACEC_SAMPLE_RESET;
        end
        else if (ch.freeze)
        begin
            state_q <= state_q;
        end
        else if (!ch.run)
        begin
            state_q  <= DACEC_IDLE;
            ch.valid <= 1'b0;
        end
        else if (ch.restart || state_q == DACEC_IDLE)
        begin
            state_q  <= DACEC_CONVERTING;
            cnt_q    <= '0;
            ch.valid <= 1'b0;
        end
        else
        begin
            case (state_q)
                DACEC_CONVERTING:
                begin
                    if (cnt_q == CONV_LAST)
                    begin
                        state_q   <= DACEC_HOLDING;
                        ch.valid  <= 1'b1;
                        ch.result <= ch.sample;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + dacec_count_t'(1);
                    end
                end
                DACEC_HOLDING:
                begin
                    state_q <= DACEC_HOLDING;
                end
                default:
                begin
                    state_q <= DACEC_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> verif/dacec_top_asserts.sv
/* Port checker for dacec_top, bound from the foot of this file.
   Assumes APB writes land at the edge with psel, penable and pready high. */
`timescale 1ns/1ns
`include "dacec_cfg.svh"
module dacec_top_asserts
    import dacec_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  drive_en_out,
    input wire logic [3:0]  result_valid_out,
    input wire logic [7:0]  analog_out_ch0
);
    localparam int CONV = `DACEC_CONV_CYCLES;
    logic       wr;
    logic       rdy;
    logic       live;
    logic [7:0] a;
    logic       stop_q;
    logic       stby_q;
    logic [8:0] since_q;
    assign wr   = psel && penable && pready && pwrite;
    assign rdy  = psel && penable && pready;
    assign live = !stop_q && !stby_q;
    assign a    = paddr[7:0];
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Power state as written; counter restarts on any channel 0 trigger
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stop_q  <= 1'b1;
            stby_q  <= 1'b0;
            since_q <= '0;
        end
        else
        begin
            if (wr && a == `DACEC_OFS_PWR_CTRL)
            begin
                stop_q <= pwdata[0];
                stby_q <= pwdata[1];
            end
            if (wr && (a == `DACEC_OFS_SAMPLE0 || a == `DACEC_OFS_LOW_CTRL
                || a == `DACEC_OFS_PWR_CTRL))
                since_q <= '0;
            else if (since_q != 9'h1ff)
                since_q <= since_q + 9'h001;
        end
    end
    property p_low_drive;
        wr && a == `DACEC_OFS_LOW_CTRL && live
        |-> ##2 drive_en_out[1:0] == $past(pwdata[7:6], 2);
    endproperty
    a_low_drive: assert property (p_low_drive) else $error("low pair drive");
    property p_high_drive;
        wr && a == `DACEC_OFS_HIGH_CTRL && live
        |-> ##2 drive_en_out[3:2] == $past(pwdata[7:6], 2);
    endproperty
    a_high_drive: assert property (p_high_drive) else $error("high pair drive");
    property p_ones;
        rdy && !pwrite && !pslverr && (a == `DACEC_OFS_LOW_CTRL || a == `DACEC_OFS_HIGH_CTRL)
        |-> prdata == {24'h00_0000, prdata[7:5], 5'h1f};
    endproperty
    a_ones: assert property (p_ones) else $error("control low bits not ones");
    property p_stop_err;
        rdy && stop_q && a != `DACEC_OFS_PWR_CTRL |-> pslverr;
    endproperty
    a_stop_err: assert property (p_stop_err) else $error("access in stop");
    property p_stop_quiet;
        stop_q && $past(stop_q, 4) |-> drive_en_out == 4'h0;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("drive in stop");
    property p_hold;
        stby_q && $past(stby_q, 8) |-> $stable(drive_en_out) && $stable(analog_out_ch0)
        && $stable(result_valid_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved in standby");
    property p_restart;
        wr && a == `DACEC_OFS_SAMPLE0 && drive_en_out[0] && live
        |-> ##[1:4] !result_valid_out[0];
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_conv;
        $rose(result_valid_out[0]) |-> since_q >= CONV;
    endproperty
    a_conv: assert property (p_conv) else $error("result too early");
    property p_held;
        result_valid_out[0] && $past(result_valid_out[0]) |-> $stable(analog_out_ch0);
    endproperty
    a_held: assert property (p_held) else $error("result not held");
    c_valid: cover property ($rose(result_valid_out[0]));
    c_err: cover property (rdy && pslverr);
    c_stby: cover property (stby_q && $past(stby_q, 8));
endmodule

bind dacec_top dacec_top_asserts i_dacec_top_asserts
(
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_en_out(drive_en_out), .result_valid_out(result_valid_out),
    .analog_out_ch0(analog_out_ch0)
);

// >>> verif/dacec_analog_model.sv
/* Analog output stage: a pin follows its code while driven, else shows the inverse of its last driven code.
   Assumes codes and enables come straight from dacec_top. */
`timescale 1ns/1ns
module dacec_analog_model
(
    input  wire logic        sys_clk_in,
    input  wire logic [3:0]  drive_en_in,
    input  wire logic [31:0] codes_in,
    output logic      [31:0] pins_out
);
    logic [31:0] last_q;
    always_comb
        for (int i = 0; i < 4; i++)
            pins_out[8*i +: 8] = drive_en_in[i] ? codes_in[8*i +: 8] : ~last_q[8*i +: 8];
    // Inverse of last level, so a stale value never passes
    always_ff @(posedge sys_clk_in)
        for (int i = 0; i < 4; i++)
            if (drive_en_in[i])
                last_q[8*i +: 8] <= codes_in[8*i +: 8];
endmodule

// >>> verif/dacec_top_tb_top.sv
/* Bench for dacec_top: APB master tasks, the analog stage model and random
   samples over every gang and enable combination.
   Assumes the port checker binds itself to dacec_top. */
`timescale 1ns/1ns
`include "dacec_cfg.svh"
module dacec_top_tb_top
    import dacec_pkg::*;
;
    localparam int CONV = `DACEC_CONV_CYCLES;
    logic        sys_clk_in;
    logic        rst_n_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  drive;
    logic [3:0]  valid;
    wire  [31:0] codes;
    logic [31:0] pins;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  w;
    logic [7:0]  smp [4];
    logic [3:0]  exp_v;
    int          cyc;
    int          cyc2;
    int          error_cnt;
    int          tests_run;

    dacec_top i_dacec_top
    (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive_en_out(drive), .result_valid_out(valid),
        .analog_out_ch0(codes[7:0]), .analog_out_ch1(codes[15:8]),
        .analog_out_ch2(codes[23:16]), .analog_out_ch3(codes[31:24])
    );
    dacec_analog_model i_dacec_analog_model
    (
        .sys_clk_in(sys_clk_in), .drive_en_in(drive), .codes_in(codes), .pins_out(pins)
    );

    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk_in);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            check(32'h0, 32'h1, "bus timeout");
            results();
        end
    endtask

    // Bounded wait for the valid pattern; bound well past one conversion
    task automatic wait_valid(input logic [3:0] e, output int n);
        n = 0;
        while (valid !== e && n < 400)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 400)
        begin
            check({28'h000_0000, valid}, {28'h000_0000, e}, "valid timeout");
            results();
        end
    endtask

    // Pair outcome from {own enable hi, own enable lo, gang}
    function automatic logic [1:0] conv(input logic [2:0] c);
        if (c[0])
            return (c[2] | c[1]) ? 2'b11 : 2'b00;
        return c[2:1];
    endfunction

    initial
    begin
        rst_n_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'h10f6_2ce8));
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        apb(1'b1, `DACEC_OFS_SAMPLE0, 32'h0000_00a5);
        apb(1'b0, `DACEC_OFS_SAMPLE0, 32'h0000_0000);
        check({31'h0, err}, 32'h1, "stop refusal");
        apb(1'b0, `DACEC_OFS_PWR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0001, "power reset");
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check({31'h0, err}, 32'h1, "unmapped");
        apb(1'b0, `DACEC_OFS_SAMPLE0, 32'h0000_0000);
        check(rd, 32'h0000_0000, "sample reset");
        apb(1'b0, `DACEC_OFS_HIGH_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_001f, "control reset");
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `DACEC_OFS_LOW_CTRL, 32'h0000_0000);
            apb(1'b1, `DACEC_OFS_HIGH_CTRL, 32'h0000_0000);
            wait_valid(4'h0, cyc);
            check({28'h0, drive}, 32'h0, "drive off");
            for (int i = 0; i < 4; i++)
            begin
                smp[i] = 8'($urandom);
                apb(1'b1, 8'(4 * i), {24'h00_0000, smp[i]});
                apb(1'b0, 8'(4 * i), 32'h0000_0000);
                check(rd, {24'h00_0000, smp[i]}, "sample");
            end
            w = {3'(c), 5'($urandom)};
            apb(1'b1, `DACEC_OFS_LOW_CTRL, {24'h00_0000, w});
            apb(1'b1, `DACEC_OFS_HIGH_CTRL, {24'h00_0000, ~w[7:5], w[4:0]});
            apb(1'b0, `DACEC_OFS_HIGH_CTRL, 32'h0000_0000);
            check(rd, {24'h00_0000, ~w[7:5], 5'h1f}, "control");
            apb(1'b0, `DACEC_OFS_LOW_CTRL, 32'h0000_0000);
            check(rd, {24'h00_0000, w[7:5], 5'h1f}, "low control");
            exp_v = {conv(~w[7:5]), conv(w[7:5])};
            wait_valid(exp_v, cyc);
            apb(1'b0, `DACEC_OFS_STATUS, 32'h0000_0000);
            check(rd, {24'h00_0000, exp_v, exp_v}, "status");
            check({28'h0, drive}, {28'h0, ~w[7:6], w[7:6]}, "drive");
            for (int i = 0; i < 4; i++)
                if (drive[i])
                    check({24'h0, pins[8*i +: 8]}, {24'h0, smp[i]}, "pin");
        end
        apb(1'b1, `DACEC_OFS_HIGH_CTRL, 32'h0000_0000);
        apb(1'b1, `DACEC_OFS_LOW_CTRL, 32'h0000_0040);
        wait_valid(4'h1, cyc);
        w = ~smp[0];
        apb(1'b1, `DACEC_OFS_SAMPLE0, {24'h00_0000, w});
        wait_valid(4'h0, cyc);
        check(cyc, 32'(cyc < 5 ? cyc : -1), "restart delay");
        check({24'h0, pins[7:0]}, {24'h0, smp[0]}, "held code");
        wait_valid(4'h1, cyc2);
        check(32'(cyc + cyc2 >= CONV - 4 && cyc + cyc2 <= CONV + 8), 32'h1, "time");
        check({24'h0, pins[7:0]}, {24'h0, w}, "new code");
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0002);
        apb(1'b1, `DACEC_OFS_SAMPLE0, {24'h00_0000, smp[0]});
        repeat (CONV + 20) @(posedge sys_clk_in);
        check({23'h0, drive[0], pins[7:0]}, {23'h0, 1'b1, w}, "standby hold");
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0000);
        wait_valid(4'h0, cyc);
        wait_valid(4'h1, cyc);
        check({24'h0, pins[7:0]}, {24'h0, smp[0]}, "after standby");
        apb(1'b1, `DACEC_OFS_LOW_CTRL, 32'h0000_0000);
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0002);
        wait_valid(4'h0, cyc);
        check({28'h0, drive}, 32'h0, "quiet standby");
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0000);
        apb(1'b1, `DACEC_OFS_HIGH_CTRL, 32'h0000_0040);
        wait_valid(4'h4, cyc);
        apb(1'b1, `DACEC_OFS_PWR_CTRL, 32'h0000_0001);
        apb(1'b0, `DACEC_OFS_HIGH_CTRL, 32'h0000_0000);
        check({31'h0, err}, 32'h1, "stop again");
        check({28'h0, drive}, 32'h0, "stop drive");
        results();
    end
endmodule
